/* ccdt_discard_timer.sv */
`timescale 1ns/1ns
`include "ccdt_regs.svh"
module ccdt_discard_timer (
  input  wire logic                    clk,             // Clock 125 MHz
  input  wire logic                    rst,             // Async reset, all three reset sources ORed
  input  wire ccdt_pkg::ccdt_cfg_req_t cfg_req,         // Config access request
  output logic [15:0]                  cfg_rdata,       // Config read data
  output logic                         cfg_hit,         // Address maps to this block
  input  wire ccdt_pkg::ccdt_cache_ev_t cache_ev,       // Cache activity
  input  wire logic [1:0]              completion_caching_policy, // Cache mode
  output logic                         discard,         // Discard pulse
  output logic                         holding          // Cache entry held
);
  import ccdt_pkg::*;

  // ----------------------------------------------------------------
  // Threshold registers
  // ----------------------------------------------------------------
  logic [`CCDT_XFR_W-1:0] idle_cycle_start_threshold_q;
  logic [`CCDT_TMR_W-1:0] tmr_min_q;
  logic [`CCDT_TMR_W-1:0] tmr_max_q;

  wire logic sel_xfr = cfg_req.addr == `CCDT_XFR_LIMIT_OFS;
  wire logic sel_min = cfg_req.addr == `CCDT_TMR_MIN_OFS;
  wire logic sel_max = cfg_req.addr == `CCDT_TMR_MAX_OFS;
  wire logic wr_lo   = cfg_req.wr && cfg_req.be[0];
  wire logic wr_hi   = cfg_req.wr && cfg_req.be[1];

  assign cfg_hit = sel_xfr || sel_min || sel_max;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cycle_start_threshold_q <= `CCDT_XFR_RST;
      tmr_min_q                    <= `CCDT_TMR_MIN_RST;
      tmr_max_q                    <= `CCDT_TMR_MAX_RST;
    end else begin
      if (sel_xfr && wr_lo) idle_cycle_start_threshold_q <= cfg_req.wdata[7:0];
      if (sel_min && wr_lo) tmr_min_q[7:0]  <= cfg_req.wdata[7:0];
      if (sel_min && wr_hi) tmr_min_q[11:8] <= cfg_req.wdata[11:8];
      if (sel_max && wr_lo) tmr_max_q[7:0]  <= cfg_req.wdata[7:0];
      if (sel_max && wr_hi) tmr_max_q[11:8] <= cfg_req.wdata[11:8];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reserved upper bits are tied to zero here, never stored
  wire logic [15:0] rd_mux = sel_xfr ? {8'h00, idle_cycle_start_threshold_q} :
                             sel_min ? {4'h0, tmr_min_q} :
                             sel_max ? {4'h0, tmr_max_q} :
                             16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 16'h0000;
    end else if (cfg_req.rd) begin
      cfg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Register checks
  // ----------------------------------------------------------------
  a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !$past(cfg_req.rd) |-> $stable(cfg_rdata))
    else $error("read data changed without a read");

  a_xfr_write: assert property (@(posedge clk) disable iff (rst)
    (cfg_req.wr && cfg_req.be[0] && sel_xfr)
      |=> idle_cycle_start_threshold_q == $past(cfg_req.wdata[7:0]))
    else $error("transfer limit write not taken");

  a_min_write: assert property (@(posedge clk) disable iff (rst)
    (cfg_req.wr && cfg_req.be[1] && sel_min)
      |=> tmr_min_q[11:8] == $past(cfg_req.wdata[11:8]))
    else $error("minimum timer upper write not taken");

  a_max_write: assert property (@(posedge clk) disable iff (rst)
    (cfg_req.wr && cfg_req.be[0] && sel_max)
      |=> tmr_max_q[7:0] == $past(cfg_req.wdata[7:0]))
    else $error("maximum timer lower write not taken");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    ($past(cfg_req.rd) && !$past(cfg_hit)) |-> cfg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_xfr_read: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_req.rd && sel_xfr) |-> cfg_rdata[7:0] == $past(idle_cycle_start_threshold_q))
    else $error("transfer limit read wrong");

  // ----------------------------------------------------------------
  // Entry state and counters
  // ----------------------------------------------------------------
  ccdt_state_t            state_q;
  logic [`CCDT_TMR_W-1:0] clk_cnt_q;
  logic [`CCDT_XFR_W-1:0] start_cnt_q;

  wire logic ev       = cache_ev.valid;
  wire logic hit      = ev && cache_ev.read_hit;
  wire logic no_cache = completion_caching_policy == `CCDT_POLICY_NONE;
  wire logic held     = state_q == CCDT_HELD;

  // ----------------------------------------------------------------
  // Discard decision
  // ----------------------------------------------------------------
  // A hit in the same cycle wins over any timeout
  wire logic min_met   = clk_cnt_q >= tmr_min_q;
  wire logic xfr_met   = start_cnt_q >= idle_cycle_start_threshold_q;
  wire logic miss_lim  = min_met && xfr_met;
  wire logic max_met   = clk_cnt_q >= tmr_max_q;
  wire logic nc_dump   = no_cache && ev && cache_ev.data_returned;
  wire logic timed_out = !no_cache && !hit && (miss_lim || max_met);

  assign discard = held && (nc_dump || timed_out);
  assign holding = held;

  // ----------------------------------------------------------------
  // Idle counters
  // ----------------------------------------------------------------
  // Saturation keeps a stale entry discardable after a long idle spell
  wire logic cnt_clr = !held || hit || discard;

  ccdt_sat_counter #(.W(`CCDT_TMR_W)) u_clk_cnt (
    .clk   (clk),
    .rst   (rst),
    .clr   (cnt_clr),
    .inc   (1'b1),
    .cnt_q (clk_cnt_q)
  );

  ccdt_sat_counter #(.W(`CCDT_XFR_W)) u_start_cnt (
    .clk   (clk),
    .rst   (rst),
    .clr   (cnt_clr),
    .inc   (ev && cache_ev.cycle_start && !cache_ev.read_hit),
    .cnt_q (start_cnt_q)
  );

  // ----------------------------------------------------------------
  // Entry state
  // ----------------------------------------------------------------
  // Entry becomes held when completion data lands in the cache (data_returned outside hold)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= CCDT_EMPTY;
    end else begin
      unique case (state_q)
        CCDT_EMPTY: if (ev && cache_ev.data_returned && !no_cache) state_q <= CCDT_HELD;
        CCDT_HELD:  if (discard) state_q <= CCDT_EMPTY;
        default:    state_q <= CCDT_EMPTY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_xfr_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_req.rd && sel_xfr) |-> cfg_rdata[15:8] == 8'h00)
    else $error("transfer limit reserved bits not zero");

  a_tmr_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_req.rd && (sel_min || sel_max)) |-> cfg_rdata[15:12] == 4'h0)
    else $error("timer reserved bits not zero");

  a_no_early_disc: assert property (@(posedge clk) disable iff (rst)
    (discard && !no_cache && !max_met) |-> (clk_cnt_q >= tmr_min_q && xfr_met))
    else $error("discard before minimum time or start count");

  a_max_discard: assert property (@(posedge clk) disable iff (rst)
    (held && !no_cache && !hit && clk_cnt_q >= tmr_max_q) |-> discard)
    else $error("no discard at maximum time");

  a_hit_restart: assert property (@(posedge clk) disable iff (rst)
    (held && hit && !discard) |=> (clk_cnt_q == 12'h000 && start_cnt_q == 8'h00))
    else $error("counters not restarted on hit");

  a_nocache_dump: assert property (@(posedge clk) disable iff (rst)
    (held && no_cache && ev && cache_ev.data_returned) |-> discard ##1 !held)
    else $error("no-cache data not discarded");

  a_disc_clears: assert property (@(posedge clk) disable iff (rst)
    discard |=> (state_q == CCDT_EMPTY && clk_cnt_q == 12'h000))
    else $error("discard did not clear entry");

  a_start_count: assert property (@(posedge clk) disable iff (rst)
    (held && !discard && ev && cache_ev.cycle_start && !cache_ev.read_hit && start_cnt_q != 8'hFF)
      |=> start_cnt_q == $past(start_cnt_q) + 8'h01)
    else $error("cycle start not counted");

  // ----------------------------------------------------------------
  // Counter and discard checks
  // ----------------------------------------------------------------
  a_min_gate: assert property (@(posedge clk) disable iff (rst)
    (held && !no_cache && clk_cnt_q < tmr_min_q && clk_cnt_q < tmr_max_q) |-> !discard)
    else $error("discard before minimum time");

  a_xfr_gate: assert property (@(posedge clk) disable iff (rst)
    (held && !no_cache && !xfr_met && clk_cnt_q < tmr_max_q) |-> !discard)
    else $error("discard before start count reached");

  a_miss_discard: assert property (@(posedge clk) disable iff (rst)
    (held && !no_cache && !hit && min_met && xfr_met) |-> discard)
    else $error("no discard at miss limit");

  a_hit_blocks: assert property (@(posedge clk) disable iff (rst)
    (held && !no_cache && hit) |-> !discard)
    else $error("discard in a hit cycle");

  a_clk_count: assert property (@(posedge clk) disable iff (rst)
    (held && !discard && !hit && clk_cnt_q != 12'hFFF)
      |=> clk_cnt_q == $past(clk_cnt_q) + 12'h001)
    else $error("clock cycle not counted");

  a_fill_hold: assert property (@(posedge clk) disable iff (rst)
    (!held && ev && cache_ev.data_returned && !no_cache)
      |=> (held && clk_cnt_q == 12'h000 && start_cnt_q == 8'h00))
    else $error("fill did not start a clean hold");

  a_nocache_idle: assert property (@(posedge clk) disable iff (rst)
    (!held && no_cache) |=> !held)
    else $error("entry held with caching off");

  a_empty_quiet: assert property (@(posedge clk) disable iff (rst)
    !held |-> !discard)
    else $error("discard without a held entry");
endmodule : ccdt_discard_timer

/* ccdt_pci_master.sv */
`timescale 1ns/1ns
// --------------------------------------------------------
// PCI master model: drives cache activity levels
// --------------------------------------------------------
module ccdt_pci_master (
  input  wire logic                valid,    // Activity qualifier
  input  wire logic                fill,     // Data returned to master
  input  wire logic                start,    // PCI cycle start
  input  wire logic                hit,      // Read hit on cached data
  output ccdt_pkg::ccdt_cache_ev_t cache_ev  // Cache activity
);
  import ccdt_pkg::*;
  assign cache_ev = '{valid: valid, read_hit: hit, cycle_start: start, data_returned: fill};
endmodule : ccdt_pci_master

/* ccdt_pkg.sv */
package ccdt_pkg;
  // Configuration access from the bridge's config space decoder
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  be;
  } ccdt_cfg_req_t;

  // Cache activity seen from the PCI side
  typedef struct packed {
    logic valid;
    logic read_hit;
    logic cycle_start;
    logic data_returned;
  } ccdt_cache_ev_t;

  typedef enum logic [1:0] {CCDT_EMPTY, CCDT_HELD} ccdt_state_t;
endpackage : ccdt_pkg

/* ccdt_regs.svh */
`ifndef CCDT_REGS_SVH
`define CCDT_REGS_SVH
// Notes on behaviour
// - Count PCI cycle starts without read hit; discard allowed once count reaches limit.
// - Transfer-limit register bits 15:8 are reserved and read as zero.
// - Miss-limit check waits until the minimum clock count passes without a hit.
// - Discard cached data once the maximum clock count passes without a hit.
// - Bits 15:12 of minimum and maximum timer registers read as zero.
// - All three thresholds return to defaults on any of the three resets.
// - Three 16-bit config registers at EAh, ECh, EEh in that order.
// - With no-caching policy, discard remaining data after first data returned.

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCDT_XFR_LIMIT_OFS   8'h00EA
`define CCDT_TMR_MIN_OFS     8'h00EC
`define CCDT_TMR_MAX_OFS     8'h00EE

// ----------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------
`define CCDT_XFR_W           8
`define CCDT_TMR_W           12
`define CCDT_XFR_RST         8'h08
`define CCDT_TMR_MIN_RST     12'h07F
`define CCDT_TMR_MAX_RST     12'h1C0
`define CCDT_POLICY_NONE     2'h0
`endif

/* ccdt_sat_counter.sv */
`timescale 1ns/1ns
// Saturating counter with clear; stops at all ones
module ccdt_sat_counter #(
  parameter int W = 12
) (
  input  wire logic         clk,   // Clock
  input  wire logic         rst,   // Async reset
  input  wire logic         clr,   // Synchronous clear
  input  wire logic         inc,   // Count enable
  output logic [W-1:0]      cnt_q  // Count value
);
  wire logic sat = &cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (inc && !sat) begin
      cnt_q <= cnt_q + W'(1);
    end
  end
endmodule : ccdt_sat_counter

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import ccdt_pkg::*;
  typedef struct packed {
    logic wr; logic [1:0] be; logic [7:0] addr; logic [15:0] wdata; logic [15:0] exp;
  } ccdt_row_t;
  logic           clk, rst, discard, holding, cfg_hit, fill, start, hit, ev_valid, seen_hit;
  logic [1:0]     policy;
  logic [15:0]    cfg_rdata;
  ccdt_cfg_req_t  cfg_req;
  ccdt_cache_ev_t cache_ev;
  int             fail_count, check_count, n, disc_n;
  ccdt_row_t rows [12] = '{
    '{1'b0, 2'h3, 8'hEA, 16'h0000, 16'h0008}, '{1'b0, 2'h3, 8'hEC, 16'h0000, 16'h007F},
    '{1'b0, 2'h3, 8'hEE, 16'h0000, 16'h01C0}, '{1'b0, 2'h3, 8'hE8, 16'h0000, 16'h0000},
    '{1'b1, 2'h3, 8'hEA, 16'hFFFF, 16'h00FF}, '{1'b1, 2'h3, 8'hEC, 16'hFFFF, 16'h0FFF},
    '{1'b1, 2'h3, 8'hEE, 16'hFFFF, 16'h0FFF}, '{1'b1, 2'h1, 8'hEE, 16'h1234, 16'h0F34},
    '{1'b1, 2'h2, 8'hEC, 16'h1234, 16'h02FF}, '{1'b1, 2'h3, 8'hEA, 16'h0002, 16'h0002},
    '{1'b1, 2'h3, 8'hEC, 16'h0004, 16'h0004}, '{1'b1, 2'h3, 8'hEE, 16'h0010, 16'h0010}};

  ccdt_discard_timer i_dut (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_hit(cfg_hit), .cache_ev(cache_ev), .completion_caching_policy(policy),
    .discard(discard), .holding(holding));
  ccdt_pci_master i_master (.valid(ev_valid), .fill(fill), .start(start), .hit(hit),
    .cache_ev(cache_ev));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task test_done;
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task cfg(input logic wr, input logic [1:0] be, input logic [7:0] addr, input logic [15:0] d);
    cfg_req = '{wr: wr, rd: !wr, addr: addr, wdata: d, be: be};
    @(posedge clk);
    seen_hit = cfg_hit;
    @(negedge clk);
    cfg_req = '0;
    @(negedge clk);
  endtask : cfg
  task fill_entry;
    fill = 1'b1;
    @(negedge clk);
    fill = 1'b0;
  endtask : fill_entry
  task wait_disc;
    n = 0;
    while (discard !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_disc

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) if (discard === 1'b1) disc_n++;
  initial begin
    #20000;
    fail_count++;
    test_done;
  end
  initial begin
    rst = 1'b1; fill = 1'b0; start = 1'b0; hit = 1'b0; policy = 2'h1; cfg_req = '0;
    ev_valid = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) cfg(1'b1, rows[i].be, rows[i].addr, rows[i].wdata);
      cfg(1'b0, 2'h3, rows[i].addr, 16'h0000);
      chk(cfg_rdata, rows[i].exp);
      chk(16'(seen_hit), {15'h0000, rows[i].addr inside {8'hEA, 8'hEC, 8'hEE}});
    end
    // --------------------------------------------------------
    // Cycle limit alone, then start limit gated by minimum time
    // --------------------------------------------------------
    fill_entry;
    chk(16'(holding), 16'h0001);
    wait_disc;
    chk(16'(n >= 13 && n <= 18), 16'h0001);
    @(negedge clk);
    chk(16'(holding), 16'h0000);
    fill_entry;
    ev_valid = 1'b0;
    start = 1'b1;
    wait_disc;
    chk(16'(n >= 13 && n <= 18), 16'h0001);
    @(negedge clk);
    ev_valid = 1'b1;
    start = 1'b1;
    fill_entry;
    wait_disc;
    chk(16'(n >= 2 && n <= 7), 16'h0001);
    @(negedge clk);
    policy = 2'h2;
    fill_entry;
    n = disc_n;
    repeat (30) begin
      hit = 1'b1;
      @(negedge clk);
      hit = 1'b0;
      @(negedge clk);
    end
    chk(16'(disc_n - n), 16'h0000);
    chk(16'(holding), 16'h0001);
    start = 1'b0;
    policy = 2'h0;
    fill = 1'b1;
    #1 chk(16'(discard), 16'h0001);
    @(negedge clk);
    fill = 1'b0;
    chk(16'(holding), 16'h0000);
    policy = 2'h1;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    cfg(1'b0, 2'h3, 8'hEE, 16'h0000);
    chk(cfg_rdata, 16'h01C0);
    cfg(1'b0, 2'h3, 8'hEA, 16'h0000);
    chk(cfg_rdata, 16'h0008);
    cfg(1'b0, 2'h3, 8'hEC, 16'h0000);
    chk(cfg_rdata, 16'h007F);
    test_done;
  end
endmodule : tb_top
